// ---- common/cpu_status_word_pkg.sv ----
// constants, field layout and carrier types of the cpu status word
package cpu_status_word_pkg;

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 32;
    localparam logic [7:0]  ADDR_STATUS_WORD = 8'h00;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int POS_PRIV     = 30;
    localparam int POS_BANK     = 29;
    localparam int POS_BLK      = 28;
    localparam int POS_LOCK_EN  = 15;
    localparam int POS_M        = 9;
    localparam int POS_Q        = 8;
    localparam int POS_IMASK_LO = 4;
    localparam int POS_S        = 1;
    localparam int POS_T        = 0;
    localparam int IMASK_W      = 4;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic       RST_PRIV    = 1'b1;
    localparam logic       RST_BANK    = 1'b1;
    localparam logic       RST_BLK     = 1'b1;
    localparam logic       RST_LOCK_EN = 1'b0;
    localparam logic [3:0] RST_IMASK = 4'hF;
    localparam logic [3:0] RST_FLAGS = 4'h0;

    // ----------------------------------------------------------------
    // instruction-owned flags, index into the flag array
    // ----------------------------------------------------------------
    localparam int FLAG_N = 4;
    localparam int FLAG_T = 0;
    localparam int FLAG_S = 1;
    localparam int FLAG_Q = 2;
    localparam int FLAG_M = 3;

    // ----------------------------------------------------------------
    // carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } bus_req_t;

    typedef struct packed {
        logic we;
        logic val;
    } flag_wr_t;

    typedef struct packed {
        logic               priv;
        logic               bank;
        logic               blk;
        logic               lock_en;
        logic               m;
        logic               q;
        logic [IMASK_W-1:0] imask;
        logic               s;
        logic               t;
    } status_fields_t;

endpackage

// ---- hw/status_flag_merge.sv ----
// next value of one instruction-owned status flag
`timescale 1ns/1ps
module status_flag_merge
    import cpu_status_word_pkg::*;
(
    input  wire logic     i_cur,     // present flag value
    input  wire flag_wr_t i_upd,     // update from an instruction unit
    input  wire logic     i_bus_we,  // status word written over the bus
    input  wire logic     i_bus_val, // flag bit of the bus write data
    output logic          o_nxt      // next flag value
);

    // ----------------------------------------------------------------
    // merge
    // ----------------------------------------------------------------
    // instruction result wins: it belongs to the instruction stream
    always_comb begin
        o_nxt = i_cur;
        if (i_upd.we) begin
            o_nxt = i_upd.val;
        end else if (i_bus_we) begin
            o_nxt = i_bus_val;
        end
    end

endmodule

// ---- hw/irq_accept_gate.sv ----
// acceptance of exceptions and masked interrupt requests
`timescale 1ns/1ps
module irq_accept_gate
    import cpu_status_word_pkg::*;
#(
    parameter int LEVEL_W = IMASK_W  // width of the request level
)
(
    input  wire logic [LEVEL_W-1:0] i_mask,       // present mask level
    input  wire logic               i_block,      // exception block bit
    input  wire logic               i_exc_req,    // exception request
    input  wire logic               i_irq_req,    // interrupt request
    input  wire logic [LEVEL_W-1:0] i_irq_level,  // interrupt request level
    output logic                    o_exc_accept, // exception taken
    output logic                    o_irq_accept  // interrupt taken
);

    // ----------------------------------------------------------------
    // level compare
    // ----------------------------------------------------------------
    function automatic logic level_unmasked(input logic [LEVEL_W-1:0] lvl,
                                            input logic [LEVEL_W-1:0] msk);
        level_unmasked = (lvl > msk);
    endfunction

    // exceptions go ahead of interrupts in the same cycle
    always_comb begin
        o_exc_accept = 1'b0;
        o_irq_accept = 1'b0;
        if (!i_block) begin
            o_exc_accept = i_exc_req;
            o_irq_accept = i_irq_req && !i_exc_req
                        && level_unmasked(i_irq_level, i_mask);
        end
    end

endmodule

// ---- hw/cpu_status_word_logic.sv ----
// cpu status word: mode, bank, block, cache lock, mask level and flags
//
// What this block does
// - reset and every taken exception or interrupt select register bank 1
// - block bit at 1 stops acceptance of exceptions and interrupts
// - block bit at 0 lets exceptions and interrupts be accepted
// - block bit goes to 1 on reset and on every taken event
// - cache lock works only while cache lock enable is 1
// - divisor sign and quotient flags held for divide instructions
// - four-bit mask level decides which request levels are masked
// - mask level untouched by interrupt acceptance, resets to all ones
// - saturation flag drives the multiply-accumulate mode
// - condition flag records true or false of compares and tests
// - condition flag also records carry, borrow, overflow or underflow
// - reserved bits read zero; software writes zero there
// - instructions change divide, saturation and condition flags in user mode
// - privilege bit 1 means privileged, 0 means user operation
`timescale 1ns/1ps
module cpu_status_word_logic
    import cpu_status_word_pkg::*;
#(
    parameter int LEVEL_W = IMASK_W  // interrupt level width
)
(
    input  wire logic                 i_core_clk,        // core clock, 125 MHz
    input  wire logic                 i_rst,             // async reset, high
    input  wire bus_req_t             i_bus,             // register bus request
    output logic [DATA_W-1:0]         o_rdata,           // read data, cycle after read
    input  wire logic                 i_exc_req,         // exception request
    input  wire logic                 i_irq_req,         // interrupt request
    input  wire logic [LEVEL_W-1:0]   i_irq_level,       // interrupt request level
    output logic                      o_exc_accept,      // exception taken
    output logic                      o_irq_accept,      // interrupt taken
    input  wire flag_wr_t [FLAG_N-1:0] i_flag_upd,       // flag writes by instructions
    input  wire logic                 i_cache_lock_req,  // cache lock use request
    output logic                      o_cache_lock_grant, // cache lock usable
    output status_fields_t            o_fields           // status fields to the core
);

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (LEVEL_W != IMASK_W) begin : g_bad_level_w
        $error("LEVEL_W must equal the mask level field width");
    end

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic               priv_ff;
    logic               bank_ff;
    logic               blk_ff;
    logic               lock_en_ff;
    logic [IMASK_W-1:0] imask_ff;
    logic [FLAG_N-1:0]  flag_ff;
    logic [FLAG_N-1:0]  nxt_flag;
    logic [DATA_W-1:0]  rdata_ff;
    logic               taken;
    logic               word_wr;
    logic               word_rd;
    logic               priv_wr;

    localparam int FLAG_POS [FLAG_N] = '{POS_T, POS_S, POS_Q, POS_M};

    // ----------------------------------------------------------------
    // acceptance
    // ----------------------------------------------------------------
    irq_accept_gate #(
        .LEVEL_W (LEVEL_W)
    ) u_accept (
        .i_mask       (imask_ff),
        .i_block      (blk_ff),
        .i_exc_req    (i_exc_req),
        .i_irq_req    (i_irq_req),
        .i_irq_level  (i_irq_level),
        .o_exc_accept (o_exc_accept),
        .o_irq_accept (o_irq_accept)
    );

    assign taken = o_exc_accept || o_irq_accept;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    // only the status word is mapped; other addresses read zero, writes vanish
    always_comb begin
        word_wr = 1'b0;
        word_rd = 1'b0;
        if (i_bus.addr == ADDR_STATUS_WORD) begin
            word_wr = i_bus.wr;
            word_rd = i_bus.rd;
        end
    end

    // user mode writes reach only the instruction-owned flags
    assign priv_wr = word_wr && priv_ff;

    // ----------------------------------------------------------------
    // mode, bank and block bits
    // ----------------------------------------------------------------
    // a taken event wins over a bus write in the same cycle
    // the privilege bit is itself privileged: user code cannot promote itself
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            priv_ff <= RST_PRIV;
            bank_ff <= RST_BANK;
            blk_ff  <= RST_BLK;
        end else if (taken) begin
            priv_ff <= 1'b1;
            bank_ff <= 1'b1;
            blk_ff  <= 1'b1;
        end else if (priv_wr) begin
            priv_ff <= i_bus.wdata[POS_PRIV];
            bank_ff <= i_bus.wdata[POS_BANK];
            blk_ff  <= i_bus.wdata[POS_BLK];
        end
    end

    // ----------------------------------------------------------------
    // cache lock enable
    // ----------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            lock_en_ff <= RST_LOCK_EN;
        end else if (priv_wr) begin
            lock_en_ff <= i_bus.wdata[POS_LOCK_EN];
        end
    end

    // grant stays combinational so a cleared enable stops the lock unit at once
    assign o_cache_lock_grant = i_cache_lock_req && lock_en_ff;

    // ----------------------------------------------------------------
    // interrupt mask level
    // ----------------------------------------------------------------
    // acceptance never loads the level, so nested masking is up to software
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            imask_ff <= RST_IMASK;
        end else if (priv_wr) begin
            imask_ff <= i_bus.wdata[POS_IMASK_LO +: IMASK_W];
        end
    end

    // ----------------------------------------------------------------
    // instruction-owned flags
    // ----------------------------------------------------------------
    for (genvar gi = 0; gi < FLAG_N; gi++) begin : g_flag
        status_flag_merge u_merge (
            .i_cur     (flag_ff[gi]),
            .i_upd     (i_flag_upd[gi]),
            .i_bus_we  (word_wr),
            .i_bus_val (i_bus.wdata[FLAG_POS[gi]]),
            .o_nxt     (nxt_flag[gi])
        );
    end

    // divide, multiply-accumulate and condition state, writable in user mode
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            flag_ff <= RST_FLAGS;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    function automatic logic [DATA_W-1:0] pack_word(input status_fields_t f);
        logic [DATA_W-1:0] w;
        w                                = '0;
        w[POS_PRIV]                      = f.priv;
        w[POS_BANK]                      = f.bank;
        w[POS_BLK]                       = f.blk;
        w[POS_LOCK_EN]                   = f.lock_en;
        w[POS_M]                         = f.m;
        w[POS_Q]                         = f.q;
        w[POS_IMASK_LO +: IMASK_W]       = f.imask;
        w[POS_S]                         = f.s;
        w[POS_T]                         = f.t;
        pack_word                        = w;
    endfunction

    // reserved positions stay zero; unmapped reads and idle cycles give zero
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_ff <= 32'h0000_0000;
        end else if (word_rd) begin
            rdata_ff <= pack_word(o_fields);
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end

    assign o_rdata = rdata_ff;

    // ----------------------------------------------------------------
    // field outputs
    // ----------------------------------------------------------------
    always_comb begin
        o_fields       = '0;
        o_fields.priv  = priv_ff;
        o_fields.bank  = bank_ff;
        o_fields.blk   = blk_ff;
        o_fields.lock_en = lock_en_ff;
        o_fields.m     = flag_ff[FLAG_M];
        o_fields.q     = flag_ff[FLAG_Q];
        o_fields.imask = imask_ff;
        o_fields.s     = flag_ff[FLAG_S];
        o_fields.t     = flag_ff[FLAG_T];
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_taken_bank_one: assert property (taken |=> bank_ff && priv_ff)
        else $error("bank select not forced to 1 after a taken event");

    a_block_stops_all: assert property (blk_ff |-> !o_exc_accept && !o_irq_accept)
        else $error("event accepted while block bit set");

    a_unblocked_exc_in: assert property (!blk_ff && i_exc_req |-> o_exc_accept)
        else $error("exception refused while block bit clear");

    a_exc_over_irq: assert property (o_exc_accept |-> !o_irq_accept)
        else $error("interrupt taken beside an exception");

    a_taken_sets_block: assert property (taken |=> blk_ff)
        else $error("block bit not set after a taken event");

    a_cache_lock_gate: assert property (
        o_cache_lock_grant == (i_cache_lock_req && lock_en_ff))
        else $error("cache lock grant disagrees with enable bit");

    a_cache_off_idle: assert property (!lock_en_ff |-> !o_cache_lock_grant)
        else $error("cache lock granted while disabled");

    a_irq_level_mask: assert property (o_irq_accept |-> i_irq_level > imask_ff)
        else $error("interrupt accepted at or below the mask level");

    a_mask_kept_accept: assert property (
        o_irq_accept && !priv_wr |=> $stable(imask_ff))
        else $error("mask level changed by interrupt acceptance");

    a_mask_hold_idle: assert property (!priv_wr |=> $stable(imask_ff))
        else $error("mask level moved without a privileged write");

    a_priv_write_lands: assert property (
        priv_wr |=> lock_en_ff == $past(i_bus.wdata[POS_LOCK_EN])
                 && imask_ff == $past(i_bus.wdata[POS_IMASK_LO +: IMASK_W]))
        else $error("privileged write did not reach the lock or mask fields");

    a_user_mode_kept: assert property (word_wr && !priv_ff && !taken |=> !priv_ff)
        else $error("user mode write raised the privilege bit");

    a_flag_from_instr: assert property (
        i_flag_upd[FLAG_T].we |=> o_fields.t == $past(i_flag_upd[FLAG_T].val))
        else $error("condition flag did not take the instruction result");

    a_sat_from_instr: assert property (
        i_flag_upd[FLAG_S].we |=> o_fields.s == $past(i_flag_upd[FLAG_S].val))
        else $error("saturation flag did not take the instruction result");

    a_quot_from_instr: assert property (
        i_flag_upd[FLAG_Q].we |=> o_fields.q == $past(i_flag_upd[FLAG_Q].val))
        else $error("quotient flag did not take the instruction result");

    a_user_flag_write: assert property (
        !priv_ff && i_flag_upd[FLAG_M].we |=> o_fields.m == $past(i_flag_upd[FLAG_M].val))
        else $error("divide flag update lost in user mode");

    a_user_no_priv: assert property (
        word_wr && !priv_ff && !taken
        |=> $stable({priv_ff, bank_ff, blk_ff, lock_en_ff, imask_ff}))
        else $error("privileged field changed by a user mode write");

    a_read_mode_bits: assert property (
        word_rd |=> o_rdata[POS_PRIV] == $past(priv_ff) && o_rdata[POS_BLK] == $past(blk_ff))
        else $error("read word disagrees with the mode or block bit");

    a_reserved_read_zero: assert property (
        $past(word_rd) |-> (o_rdata & ~pack_word('1)) == 32'h0000_0000)
        else $error("reserved status word bit read as one");

    a_read_one_cycle: assert property (
        !$past(word_rd) |-> o_rdata == 32'h0000_0000)
        else $error("read data outside the answer cycle");

    // ----------------------------------------------------------------
    // cover points
    // ----------------------------------------------------------------
    c_exc_taken: cover property (o_exc_accept ##1 blk_ff);
    c_irq_taken: cover property (o_irq_accept ##1 bank_ff);
    c_user_write: cover property (word_wr && !priv_ff);
    c_user_flag: cover property (!priv_ff && i_flag_upd[FLAG_S].we);
    c_flag_beats_bus: cover property (word_wr && i_flag_upd[FLAG_T].we);

endmodule

// ---- testbench/cpu_status_word_logic_bench.sv ----
// self-checking bench for the cpu status word block
`timescale 1ns/1ps
module cpu_status_word_logic_bench;
    import cpu_status_word_pkg::*;

    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic                     i_core_clk;
    logic                     i_rst;
    bus_req_t                 i_bus;
    logic [DATA_W-1:0]        o_rdata;
    logic                     i_exc_req;
    logic                     i_irq_req;
    logic [IMASK_W-1:0]       i_irq_level;
    logic                     o_exc_accept;
    logic                     o_irq_accept;
    flag_wr_t [FLAG_N-1:0]    i_flag_upd;
    logic                     i_cache_lock_req;
    logic                     o_cache_lock_grant;
    status_fields_t           o_fields;
    int                       err_total;
    int                       total_checks;
    int                       cyc;
    int                       flag_pos [FLAG_N] = '{POS_T, POS_S, POS_Q, POS_M};
    logic [31:0]              exp_word;

    cpu_status_word_logic DUT (
        .i_core_clk         (i_core_clk),
        .i_rst              (i_rst),
        .i_bus              (i_bus),
        .o_rdata            (o_rdata),
        .i_exc_req          (i_exc_req),
        .i_irq_req          (i_irq_req),
        .i_irq_level        (i_irq_level),
        .o_exc_accept       (o_exc_accept),
        .o_irq_accept       (o_irq_accept),
        .i_flag_upd         (i_flag_upd),
        .i_cache_lock_req   (i_cache_lock_req),
        .o_cache_lock_grant (o_cache_lock_grant),
        .o_fields           (o_fields)
    );

    always #4 i_core_clk = ~i_core_clk;

    // ----------------------------------------------------------------
    // report, compare and access tasks
    // ----------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // the whole run needs well under a thousand cycles
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total = err_total + 1;
            wrap_up();
        end
    end

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_core_clk);
        i_bus <= '0;
    endtask

    // data stand only in the cycle after the strobe, then return to zero
    task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_core_clk);
        i_bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge i_core_clk);
        i_bus <= '0;
        #1;
        chk32(o_rdata, exp);
        @(posedge i_core_clk);
        #1;
        chk32(o_rdata, 32'h0);
    endtask

    task automatic irq_try(input logic [3:0] lvl, input logic exp);
        @(posedge i_core_clk);
        i_irq_req   <= 1'b1;
        i_irq_level <= lvl;
        #1;
        chk1(o_irq_accept, exp);
        @(posedge i_core_clk);
        i_irq_req <= 1'b0;
    endtask

    task automatic exc_try(input logic exp);
        @(posedge i_core_clk);
        i_exc_req <= 1'b1;
        #1;
        chk1(o_exc_accept, exp);
        @(posedge i_core_clk);
        i_exc_req <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        i_core_clk = 1'b0;
        i_rst = 1'b1;
        i_bus = '0;
        i_exc_req = 1'b0;
        i_irq_req = 1'b0;
        i_irq_level = 4'h0;
        i_flag_upd = '0;
        i_cache_lock_req = 1'b0;
        err_total = 0;
        total_checks = 0;
        cyc = 0;
        repeat (4) @(posedge i_core_clk);
        i_rst <= 1'b0;
        bus_rd(ADDR_STATUS_WORD, 32'h700000F0);
        exc_try(1'b0);
        // reserved bits written as ones must read back zero
        bus_wr(ADDR_STATUS_WORD, 32'hCFFFFF5F);
        bus_rd(ADDR_STATUS_WORD, 32'h40008353);
        bus_rd(8'h04, 32'h0);
        @(posedge i_core_clk);
        i_cache_lock_req <= 1'b1;
        #1;
        chk1(o_cache_lock_grant, 1'b1);
        irq_try(4'h5, 1'b0);
        irq_try(4'h6, 1'b1);
        bus_rd(ADDR_STATUS_WORD, 32'h70008353);
        exc_try(1'b0);
        irq_try(4'hF, 1'b0);
        bus_wr(ADDR_STATUS_WORD, 32'h40008350);
        exc_try(1'b1);
        bus_rd(ADDR_STATUS_WORD, 32'h70008350);
        bus_wr(ADDR_STATUS_WORD, 32'h40008350);
        // exception and interrupt together: exception wins
        @(posedge i_core_clk);
        i_exc_req   <= 1'b1;
        i_irq_req   <= 1'b1;
        i_irq_level <= 4'hF;
        #1;
        chk1(o_exc_accept, 1'b1);
        chk1(o_irq_accept, 1'b0);
        @(posedge i_core_clk);
        i_exc_req <= 1'b0;
        i_irq_req <= 1'b0;
        // drop to user mode, then try to change privileged fields
        bus_wr(ADDR_STATUS_WORD, 32'h0);
        bus_rd(ADDR_STATUS_WORD, 32'h0);
        #1;
        chk1(o_cache_lock_grant, 1'b0);
        bus_wr(ADDR_STATUS_WORD, 32'h700083F3);
        bus_rd(ADDR_STATUS_WORD, 32'h00000303);
        exp_word = 32'h00000303;
        for (int i = 0; i < FLAG_N; i++) begin
            @(posedge i_core_clk);
            i_flag_upd[i] <= '{we: 1'b1, val: 1'b0};
            @(posedge i_core_clk);
            i_flag_upd[i] <= '0;
            exp_word[flag_pos[i]] = 1'b0;
            bus_rd(ADDR_STATUS_WORD, exp_word);
        end
        // instruction update beats a bus write of the same flag
        @(posedge i_core_clk);
        i_bus <= '{addr: ADDR_STATUS_WORD, wdata: 32'h0, wr: 1'b1, rd: 1'b0};
        i_flag_upd[FLAG_T] <= '{we: 1'b1, val: 1'b1};
        @(posedge i_core_clk);
        i_bus <= '0;
        i_flag_upd[FLAG_T] <= '0;
        bus_rd(ADDR_STATUS_WORD, 32'h00000001);
        exc_try(1'b1);
        bus_rd(ADDR_STATUS_WORD, 32'h70000001);
        // reset again in mid-run
        @(posedge i_core_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        bus_rd(ADDR_STATUS_WORD, 32'h700000F0);
        wrap_up();
    end
endmodule
